//--- memboard_pkg.sv
// Shared constants and types for the expansion memory board glue logic.
// Assumes a 40 MHz system clock; every bus input is synchronous to it.
package memboard_pkg;

   // Timing
   localparam int CLK_MHZ           = 40;
   localparam int MUX_DELAY_NS      = 30;
   localparam int CAS_DELAY_NS      = 70;
   localparam int REFRESH_PERIOD_NS = 15000;
   localparam int MUX_DELAY_CYC     = (MUX_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int CAS_DELAY_CYC     = (CAS_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int REFRESH_CYC       = (REFRESH_PERIOD_NS * CLK_MHZ) / 1000;
   localparam logic [2:0] MUX_DELAY_CNT = 3'(MUX_DELAY_CYC);
   localparam logic [2:0] CAS_DELAY_CNT = 3'(CAS_DELAY_CYC);
   localparam logic [9:0] REFRESH_LAST  = 10'(REFRESH_CYC - 1);
   localparam int WAIT_OSC_EDGES_DEF    = 3;

   // Memory window, in 64K pages of A19-A16
   localparam logic [3:0] BASE_PAGE_DMA    = 4'h0;
   localparam logic [3:0] BASE_PAGE_NO_DMA = 4'h4;
   localparam logic [3:0] BANKS_SMALL      = 4'h2;
   localparam logic [3:0] BANKS_LARGE      = 4'h4;

   // I/O map
   localparam logic [15:0] DMA_PAGE_UNUSED_OFS   = 16'h0080;
   localparam logic [15:0] DMA_PAGE_CH2_OFS      = 16'h0081;
   localparam logic [15:0] DMA_PAGE_CH3_OFS      = 16'h0082;
   localparam logic [15:0] DMA_PAGE_CH01_OFS     = 16'h0083;
   localparam logic [15:0] DMA_CTRL_OFS          = 16'h0000;
   localparam logic [15:0] DMA_CTRL_MASK         = 16'hfff0;
   localparam logic [15:0] DMA_PAGE_MASK         = 16'hfffc;
   localparam int          PAGE_WIDTH            = 4;
   localparam logic [3:0]  PAGE_RESET            = 4'h0;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_ROW  = 4'h2,
      SEQ_MUX  = 4'h4,
      SEQ_CAS  = 4'h8
   } seq_state_e;

endpackage

//--- mem_seq_if.sv
// Carrier between the board decode logic and the DRAM strobe sequencer.
// Requests come from the decode side; strobes come back registered.
`timescale 1ns/1ps
interface mem_seq_if;
   logic       start;        // One-cycle cycle start
   logic       active;       // Memory command still asserted
   logic       refresh;      // Cycle is a refresh read
   logic       write;        // Cycle is a memory write
   logic       osc_rise;     // Bus oscillator rising edge seen
   logic [3:0] bank_onehot;  // Selected bank
   logic [3:0] row_n;        // Row strobes, active low
   logic       col_n;        // Column strobe, active low
   logic       mux_sel;      // Address multiplex control
   logic       wr_n;         // DRAM write control, active low

   modport ctrl (output start, active, refresh, write, osc_rise, bank_onehot,
                 input row_n, col_n, mux_sel, wr_n);
   modport seq  (input start, active, refresh, write, osc_rise, bank_onehot,
                 output row_n, col_n, mux_sel, wr_n);
endinterface

//--- dram_sequencer.sv
// DRAM strobe sequencer: the clocked delay line of the board.
// Assumes start is a one-cycle pulse and active stays high until the command ends.
`timescale 1ns/1ps
module dram_sequencer (
   input  wire logic clk,      // 40 MHz
   input  wire logic sys_rst,  // Synchronous reset, active high
   mem_seq_if.seq    sq        // Request and strobe bundle
);

   typedef struct packed {
      memboard_pkg::seq_state_e state;
      logic [2:0]               cyc;
      logic                     osc_seen;
      logic                     refresh;
      logic [3:0]               row_n;
      logic                     col_n;
      logic                     mux;
      logic                     wr_n;
   } seq_s;

   localparam seq_s SEQ_RESET = '{state: memboard_pkg::SEQ_IDLE, row_n: 4'hf,
                                  col_n: 1'b1, wr_n: 1'b1, default: '0};

   if (memboard_pkg::CAS_DELAY_CYC > 7 || memboard_pkg::MUX_DELAY_CYC < 1)
      $error("Delay line counts do not fit the 3-bit stage counter");

   seq_s s_reg;
   seq_s s_next;

   always_comb begin
      s_next = s_reg;
      if (s_reg.cyc != 3'h7)
         s_next.cyc = s_reg.cyc + 3'h1;
      if (sq.osc_rise)
         s_next.osc_seen = 1'b1;
      unique case (s_reg.state)
         memboard_pkg::SEQ_IDLE: begin
            s_next.cyc      = '0;
            s_next.osc_seen = 1'b0;
            if (sq.start) begin
               s_next.refresh = sq.refresh;
               // All rows at once for refresh, else the decoded bank
               s_next.row_n   = sq.refresh ? 4'h0 : ~sq.bank_onehot;
               s_next.state   = memboard_pkg::SEQ_ROW;
            end
         end
         memboard_pkg::SEQ_ROW: begin
            // Refresh never leaves this stage, so mux and column stay idle
            if (!s_reg.refresh && s_reg.osc_seen && s_reg.cyc >= memboard_pkg::MUX_DELAY_CNT) begin
               s_next.mux      = 1'b1;
               s_next.wr_n     = ~sq.write;
               s_next.osc_seen = 1'b0;
               s_next.state    = memboard_pkg::SEQ_MUX;
            end
         end
         memboard_pkg::SEQ_MUX: begin
            // Next oscillator rising edge after the mux stage, at least CAS_DELAY_CNT cycles from the row strobe
            if (s_reg.osc_seen && s_reg.cyc >= memboard_pkg::CAS_DELAY_CNT) begin
               s_next.col_n = 1'b0;
               s_next.state = memboard_pkg::SEQ_CAS;
            end
         end
         memboard_pkg::SEQ_CAS: begin
            s_next.col_n = 1'b0;
         end
         default: s_next = SEQ_RESET;
      endcase
      // Everything drops with the command, ready for the next cycle
      if (s_reg.state != memboard_pkg::SEQ_IDLE && !sq.active)
         s_next = SEQ_RESET;
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         s_reg <= SEQ_RESET;
      else
         s_reg <= s_next;
   end

   assign sq.row_n   = s_reg.row_n;
   assign sq.col_n   = s_reg.col_n;
   assign sq.mux_sel = s_reg.mux;
   assign sq.wr_n    = s_reg.wr_n;

endmodule

//--- memory_board_dram_dma_glue.sv
// Glue logic of a byte-wide expansion memory board with optional DMA support:
// bank decode, DRAM strobes, page registers, upper address latch, buffer
// enables, refresh request and DMA wait states.
// Assumes all bus inputs are synchronous to clk and the jumpers are static.
`timescale 1ns/1ps

// Functional notes
// - Size jumper fitted gives 256K of memory, absent gives 128K.
// - Base jumper fitted: no DMA, base 40000h; absent: DMA, base 00000h.
// - Strobe timing follows the 14.31818 MHz bus oscillator; the refresh timer counts clk.
// - Outside refresh, a memory command in the window drives exactly one row strobe, chosen by jumpers and A16-A19.
// - Delay line raises mux and write controls no sooner than 30ns, column no sooner than 70ns.
// - A memory read flagged as refresh asserts all four row strobes.
// - Refresh cycles keep the mux control and column strobe inactive.
// - DRAM address is A0-A7 normally, A8-A15 while mux is asserted.
// - Channels 1-3 use a request raised by the peripheral, channel 0 the refresh timer; each answered by acknowledge.
// - During DMA the controller drives A0-A15 and paired strobes in one cycle.
// - The DMA controller is selected by sixteen contiguous I/O addresses.
// - Page registers 080-083 take D0-D3 and drive A16-A19 during DMA.
// - Page 80 unused; 81 channel 2; 82 channel 3; 83 channels 0 and 1.
// - A 15 us pulse sets the refresh request; acknowledge clears it, marks refresh.
// - Channel 2 serves the floppy controller; channels 1 and 3 go to the bus.
// - The upper address byte is latched at the address strobe falling edge.
// - DMA address enable opens latch, address and command buffers only in DMA.
// - Data buffer enabled in DMA and for processor accesses to the board.
// - Ready is synchronised and one wait state added on DMA I/O strobes.
// - Without DMA fitted, page register accesses have no effect.
module memory_board_dram_dma_glue #(
   parameter int WAIT_OSC_EDGES = memboard_pkg::WAIT_OSC_EDGES_DEF
) (
   input  wire logic        clk,                    // 40 MHz system clock
   input  wire logic        sys_rst,                // Synchronous reset, active high
   input  wire logic        size_jumper,            // 1 = 256K fitted
   input  wire logic        base_jumper,            // 1 = no DMA, base 40000h
   input  wire logic        bus_oscillator,         // 14.31818 MHz bus oscillator level
   input  wire logic [19:0] bus_addr,               // Expansion bus address
   input  wire logic        memory_read_n,          // Memory read command
   input  wire logic        memory_write_n,         // Memory write command
   input  wire logic        io_read_n,              // I/O read command
   input  wire logic        io_write_n,             // I/O write command
   input  wire logic [7:0]  bus_data,               // Data lines, also DMA upper address
   input  wire logic [7:0]  dma_addr_lo,            // Controller address A0-A7
   input  wire logic        dma_upper_addr_strobe,  // Upper address on data lines when high
   input  wire logic        dma_addr_enable_n,      // Low during DMA cycles
   input  wire logic [3:0]  dma_cmd_n,              // Controller {iow, ior, memw, memr}
   input  wire logic [3:0]  dma_ack_n,              // Controller acknowledges 3..0
   input  wire logic        floppy_req,             // Floppy controller request
   input  wire logic [1:0]  bus_req,                // Bus requests for channels 3,1
   input  wire logic        ready_in,               // Bus ready
   output logic      [3:0]  row_strobe_n,           // DRAM row strobes
   output logic             col_strobe_n,           // DRAM column strobe
   output logic             dram_addr_mux_sel,      // High selects A8-A15
   output logic             dram_write_n,           // DRAM write control
   output logic      [7:0]  dram_addr,              // Multiplexed DRAM address
   output logic      [19:0] dma_addr_out,           // Buffered DMA address
   output logic             dma_addr_oe,            // Enable for address and command buffers
   output logic      [3:0]  bus_cmd_n,              // Buffered DMA command strobes
   output logic             data_buf_en_n,          // Board data buffer enable
   output logic             dma_ctrl_sel_n,         // DMA controller select
   output logic      [3:0]  dma_req,                // Requests to controller
   output logic             floppy_ack_n,           // Channel 2 acknowledge out
   output logic      [1:0]  bus_ack_n,              // Channel 3,1 acknowledges out
   output logic             dma_ready,              // Ready to controller
   output logic             refresh_cycle           // Current cycle is refresh
);

   if (WAIT_OSC_EDGES < 1 || WAIT_OSC_EDGES > 3)
      $error("WAIT_OSC_EDGES must lie in 1..3");

   localparam logic [1:0] WAIT_LOAD = 2'(WAIT_OSC_EDGES);

   typedef struct packed {
      logic                                 osc_prev;
      logic                                 mem_cmd_prev;
      logic                                 io_wr_prev;
      logic                                 io_rd_prev;
      logic                                 strobe_prev;
      logic [memboard_pkg::PAGE_WIDTH-1:0]  page_ch2;
      logic [memboard_pkg::PAGE_WIDTH-1:0]  page_ch3;
      logic [memboard_pkg::PAGE_WIDTH-1:0]  page_ch01;
      logic [7:0]                           upper_latch;
      logic                                 refresh_req;
      logic [9:0]                           refresh_cnt;
      logic [1:0]                           wait_cnt;
      logic [7:0]                           dram_addr;
      logic [19:0]                          dma_addr;
      logic                                 dma_addr_oe;
      logic [3:0]                           bus_cmd_n;
      logic                                 data_buf_en_n;
      logic                                 dma_ctrl_sel_n;
      logic [3:0]                           dma_req;
      logic                                 floppy_ack_n;
      logic [1:0]                           bus_ack_n;
      logic                                 dma_ready;
      logic                                 refresh_cycle;
   } glue_s;

   localparam glue_s GLUE_RESET = '{
      mem_cmd_prev:   1'b0,
      io_wr_prev:     1'b1,
      io_rd_prev:     1'b1,
      page_ch2:       memboard_pkg::PAGE_RESET,
      page_ch3:       memboard_pkg::PAGE_RESET,
      page_ch01:      memboard_pkg::PAGE_RESET,
      bus_cmd_n:      4'hf,
      data_buf_en_n:  1'b1,
      dma_ctrl_sel_n: 1'b1,
      floppy_ack_n:   1'b1,
      bus_ack_n:      2'h3,
      default:        '0
   };

   // Address matches an I/O block under a mask
   function automatic logic io_match(input logic [15:0] a,
                                     input logic [15:0] ofs,
                                     input logic [15:0] mask);
      io_match = (a & mask) == (ofs & mask);
   endfunction

   // Bank index relative to the configured base, valid when inside the window
   function automatic logic [4:0] bank_decode(input logic [3:0] page,
                                              input logic       size_big,
                                              input logic       no_dma);
      logic [3:0] base;
      logic [3:0] rel;
      logic [3:0] banks;
      base  = no_dma ? memboard_pkg::BASE_PAGE_NO_DMA : memboard_pkg::BASE_PAGE_DMA;
      banks = size_big ? memboard_pkg::BANKS_LARGE : memboard_pkg::BANKS_SMALL;
      rel   = page - base;
      bank_decode = {(page >= base) && (rel < banks), rel};
   endfunction

   glue_s g_reg;
   glue_s g_next;

   mem_seq_if seq_bus ();

   logic       dma_fitted;
   logic       dma_cycle;
   logic       cpu_cycle;
   logic       mem_cmd;
   logic       refresh_rd;
   logic [4:0] bank_info;
   logic       in_range;
   logic       io_cmd;
   logic       page_hit;
   logic       ctrl_hit;
   logic [3:0] page_sel;

   always_comb begin
      dma_fitted = !base_jumper;
      dma_cycle  = !dma_addr_enable_n;
      cpu_cycle  = !dma_cycle;
      mem_cmd    = !memory_read_n || !memory_write_n;
      // Refresh is a memory read while channel 0 is acknowledged
      refresh_rd = !memory_read_n && !dma_ack_n[0] && dma_fitted;
      bank_info  = bank_decode(bus_addr[19:16], size_jumper, base_jumper);
      in_range   = bank_info[4];
      io_cmd     = !io_read_n || !io_write_n;
      page_hit   = dma_fitted && cpu_cycle
                   && io_match(bus_addr[15:0], memboard_pkg::DMA_PAGE_UNUSED_OFS,
                               memboard_pkg::DMA_PAGE_MASK);
      ctrl_hit   = dma_fitted && cpu_cycle
                   && io_match(bus_addr[15:0], memboard_pkg::DMA_CTRL_OFS,
                               memboard_pkg::DMA_CTRL_MASK);
      // Channel page in use: 83 for channels 0/1, 81 for 2, 82 for 3
      if (!dma_ack_n[2])
         page_sel = g_reg.page_ch2;
      else if (!dma_ack_n[3])
         page_sel = g_reg.page_ch3;
      else
         page_sel = g_reg.page_ch01;
   end

   // Requests to the sequencer
   always_comb begin
      seq_bus.start       = mem_cmd && !g_reg.mem_cmd_prev
                            && (in_range || refresh_rd);
      seq_bus.active      = mem_cmd;
      seq_bus.refresh     = refresh_rd;
      seq_bus.write       = !memory_write_n;
      seq_bus.osc_rise    = bus_oscillator && !g_reg.osc_prev;
      seq_bus.bank_onehot = 4'h1 << bank_info[1:0];
   end

   dram_sequencer u_seq (
      .clk     (clk),
      .sys_rst (sys_rst),
      .sq      (seq_bus.seq)
   );

   always_comb begin
      g_next              = g_reg;
      g_next.osc_prev     = bus_oscillator;
      g_next.mem_cmd_prev = mem_cmd;
      g_next.io_wr_prev   = io_write_n;
      g_next.io_rd_prev   = io_read_n;
      g_next.strobe_prev  = dma_upper_addr_strobe;

      // Row address by default, column byte once the mux control is up
      g_next.dram_addr = seq_bus.mux_sel ? bus_addr[15:8] : bus_addr[7:0];

      // Page registers take the data at the trailing edge of the write,
      // while address and data are still held by the processor
      if (g_reg.io_wr_prev == 1'b0 && io_write_n && page_hit) begin
         unique case (bus_addr[1:0])
            2'h1: g_next.page_ch2  = bus_data[3:0];
            2'h2: g_next.page_ch3  = bus_data[3:0];
            2'h3: g_next.page_ch01 = bus_data[3:0];
            2'h0: ;
         endcase
      end

      // Upper address byte from the shared data lines
      if (g_reg.strobe_prev && !dma_upper_addr_strobe)
         g_next.upper_latch = bus_data;

      // Buffered DMA address and strobe pairs, opened only in DMA
      g_next.dma_addr    = {page_sel, g_reg.upper_latch, dma_addr_lo};
      g_next.dma_addr_oe = dma_cycle && dma_fitted;
      g_next.bus_cmd_n   = (dma_cycle && dma_fitted) ? dma_cmd_n : 4'hf;

      // Data buffer: DMA, in-range memory, or board I/O
      g_next.data_buf_en_n = !((dma_cycle && dma_fitted)
                               || (cpu_cycle && mem_cmd && in_range)
                               || (io_cmd && (page_hit || ctrl_hit)));
      g_next.dma_ctrl_sel_n = !(ctrl_hit && io_cmd);

      // Refresh timer: set wins over the acknowledge clearing it
      if (g_reg.refresh_cnt == memboard_pkg::REFRESH_LAST)
         g_next.refresh_cnt = '0;
      else
         g_next.refresh_cnt = g_reg.refresh_cnt + 10'h1;
      if (!dma_ack_n[0])
         g_next.refresh_req = 1'b0;
      if (g_reg.refresh_cnt == memboard_pkg::REFRESH_LAST)
         g_next.refresh_req = 1'b1;
      g_next.refresh_cycle = !dma_ack_n[0] && dma_fitted;

      // Request routing: refresh, floppy, two uncommitted bus channels
      g_next.dma_req = dma_fitted
                       ? {bus_req[1], floppy_req, bus_req[0], g_reg.refresh_req}
                       : 4'h0;
      g_next.floppy_ack_n = dma_ack_n[2] || !dma_fitted;
      g_next.bus_ack_n    = dma_fitted ? {dma_ack_n[3], dma_ack_n[1]} : 2'h3;

      // One processor clock of wait on each DMA I/O strobe
      if (dma_cycle && ((g_reg.io_rd_prev && !io_read_n) || (g_reg.io_wr_prev && !io_write_n)))
         g_next.wait_cnt = WAIT_LOAD;
      else if (seq_bus.osc_rise && g_reg.wait_cnt != 2'h0)
         g_next.wait_cnt = g_reg.wait_cnt - 2'h1;
      // Ready is resampled here so the controller sees it on its own clock
      g_next.dma_ready = ready_in && (g_next.wait_cnt == 2'h0);
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         g_reg <= GLUE_RESET;
      else
         g_reg <= g_next;
   end

   // Strobes come from the sequencer's own flip-flops
   assign row_strobe_n      = seq_bus.row_n;
   assign col_strobe_n      = seq_bus.col_n;
   assign dram_addr_mux_sel = seq_bus.mux_sel;
   assign dram_write_n      = seq_bus.wr_n;
   assign dram_addr         = g_reg.dram_addr;
   assign dma_addr_out      = g_reg.dma_addr;
   assign dma_addr_oe       = g_reg.dma_addr_oe;
   assign bus_cmd_n         = g_reg.bus_cmd_n;
   assign data_buf_en_n     = g_reg.data_buf_en_n;
   assign dma_ctrl_sel_n    = g_reg.dma_ctrl_sel_n;
   assign dma_req           = g_reg.dma_req;
   assign floppy_ack_n      = g_reg.floppy_ack_n;
   assign bus_ack_n         = g_reg.bus_ack_n;
   assign dma_ready         = g_reg.dma_ready;
   assign refresh_cycle     = g_reg.refresh_cycle;

endmodule

//--- memboard_checker.sv
// Port-level checks for the memory board glue logic.
// Assumes it is bound into the top module with every pin connected by name.
`timescale 1ns/1ps
module memboard_checker #(
   parameter int WAIT_OSC_EDGES = 3
) (
   input wire logic        clk,                // System clock
   input wire logic        sys_rst,            // Reset
   input wire logic        size_jumper,        // Size option
   input wire logic        base_jumper,        // Base option
   input wire logic [19:0] bus_addr,           // Bus address
   input wire logic        memory_read_n,      // Memory read
   input wire logic        memory_write_n,     // Memory write
   input wire logic        io_read_n,          // I/O read
   input wire logic        io_write_n,         // I/O write
   input wire logic        dma_addr_enable_n,  // DMA cycle
   input wire logic [3:0]  dma_ack_n,          // Acknowledges
   input wire logic [3:0]  row_strobe_n,       // Row strobes
   input wire logic        col_strobe_n,       // Column strobe
   input wire logic        dram_addr_mux_sel,  // Mux control
   input wire logic        dram_write_n,       // Write control
   input wire logic [7:0]  dram_addr,          // DRAM address
   input wire logic        dma_addr_oe,        // Buffer enable
   input wire logic        dma_ctrl_sel_n,     // Controller select
   input wire logic        dma_ready,          // Ready out
   input wire logic        refresh_cycle       // Refresh flag
);
   logic       mem_idle;
   logic [3:0] page;
   logic       in_win;
   logic       dma_on;
   assign mem_idle = memory_read_n & memory_write_n;
   assign page     = bus_addr[19:16] - (base_jumper ? 4'h4 : 4'h0);
   assign in_win   = page < (size_jumper ? 4'h4 : 4'h2);
   assign dma_on   = !dma_addr_enable_n && !base_jumper;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_cmd_end;
      $rose(mem_idle) ##0 row_strobe_n != 4'hf;
   endsequence
   sequence s_released;
      row_strobe_n == 4'hf && col_strobe_n && !dram_addr_mux_sel && dram_write_n;
   endsequence
   a_one_row: assert property (row_strobe_n != 4'h0 |-> $onehot0(~row_strobe_n))
      else $error("more than one row strobe low");
   a_refresh_quiet: assert property (row_strobe_n == 4'h0 |-> col_strobe_n && !dram_addr_mux_sel)
      else $error("column or mux active in refresh");
   a_col_after_mux: assert property ($fell(col_strobe_n) |-> $past(dram_addr_mux_sel))
      else $error("column strobe before mux");
   a_mux_addr_pick: assert property (!$past(sys_rst) |-> dram_addr == ($past(dram_addr_mux_sel) ?
      $past(bus_addr[15:8]) : $past(bus_addr[7:0])))
      else $error("dram address half wrong");
   a_release_together: assert property (s_cmd_end ##1 mem_idle |-> ##1 s_released)
      else $error("strobes not released together");
   a_out_window: assert property ($fell(mem_idle) && !in_win && dma_ack_n[0] && row_strobe_n == 4'hf
      |-> ##1 (row_strobe_n == 4'hf)[*3])
      else $error("row strobe outside window");
   a_addr_enable: assert property (!$past(sys_rst) |-> dma_addr_oe == $past(dma_on))
      else $error("address buffer enable wrong");
   a_ctrl_decode: assert property (!$past(sys_rst) |-> dma_ctrl_sel_n == !$past(!base_jumper
      && dma_addr_enable_n && !(io_read_n && io_write_n) && bus_addr[15:4] == 12'h000))
      else $error("controller select wrong");
   a_refresh_flag: assert property (!$past(sys_rst) |-> refresh_cycle == $past(!dma_ack_n[0]
      && !base_jumper))
      else $error("refresh flag wrong");
   a_wait_state: assert property (dma_on && $fell(io_read_n) |-> ##1 (!dma_ready)[*4])
      else $error("no wait state on DMA read");
endmodule

//--- host_side_model.sv
// Stand-in for the host side: bus oscillator and refresh acknowledge.
// Assumes the request is seen on the system clock.
`timescale 1ns/1ps
module host_side_model (
   input  wire logic clk,     // System clock
   input  wire logic req0,    // Refresh request
   output logic      osc,     // Bus oscillator
   output logic      ack0_n,  // Refresh acknowledge
   output logic [7:0] rf_row  // Row of the next refresh read
);
   initial begin
      osc = 1'b0;
      forever #34.92 osc = ~osc;  // Three times the processor rate
   end
   // Acknowledge held long enough for one refresh read
   initial begin
      ack0_n = 1'b1;
      rf_row = 8'h00;
      forever begin
         @(negedge clk);
         if (req0 && ack0_n) begin
            repeat (3) @(negedge clk);
            ack0_n = 1'b0;
            repeat (24) @(negedge clk);
            ack0_n = 1'b1;
            rf_row = rf_row + 8'h1;  // Rows in sequence
         end
      end
   end
endmodule

//--- tb_memory_board_dram_dma_glue.sv
// Self-checking bench for the memory board glue logic.
// Assumes the host stand-in supplies the oscillator and refresh acknowledge.
`timescale 1ns/1ps
module tb_memory_board_dram_dma_glue;
   logic        clk, sys_rst, size_jumper, base_jumper, bus_oscillator, ack0_n;
   logic        memory_read_n, memory_write_n, io_read_n, io_write_n, ready_in;
   logic        dma_upper_addr_strobe, dma_addr_enable_n, floppy_req, col_strobe_n;
   logic        dram_addr_mux_sel, dram_write_n, dma_addr_oe, data_buf_en_n;
   logic        dma_ctrl_sel_n, floppy_ack_n, dma_ready, refresh_cycle;
   logic [19:0] bus_addr, dma_addr_out;
   logic [7:0]  bus_data, dma_addr_lo, dram_addr, rf_row;
   logic [3:0]  dma_cmd_n, row_strobe_n, bus_cmd_n, dma_req, dma_ack_n;
   logic [2:0]  ack_hi;
   logic [1:0]  bus_req, bus_ack_n;
   logic [2:0]  ack_tab [3] = '{3'b101, 3'b011, 3'b110};
   int          n_errors, tests_run;
   assign dma_ack_n = {ack_hi, ack0_n};
   memory_board_dram_dma_glue dut (.*);
   host_side_model host (.clk(clk), .req0(dma_req[0]), .osc(bus_oscillator),
                         .ack0_n(ack0_n), .rf_row(rf_row));
   task automatic check(input string nm, input logic [19:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic mem_cycle(input logic [19:0] a, input logic wr, input logic [3:0] row);
      bus_addr = a;
      memory_read_n = wr;
      memory_write_n = !wr;
      repeat (3) @(negedge clk);
      check("row", 20'(row), 20'(row_strobe_n));
      repeat (12) @(negedge clk);
      if (row != 4'hf && row != 4'h0) begin
         check("col", 20'h0, 20'(col_strobe_n));
         check("wr", 20'(!wr), 20'(dram_write_n));
         check("addr", 20'(a[15:8]), 20'(dram_addr));
      end
      memory_read_n = 1'b1;
      memory_write_n = 1'b1;
      repeat (3) @(negedge clk);
      check("rel", 20'hf, 20'(row_strobe_n));
   endtask
   task automatic io_wr(input logic [19:0] a, input logic [7:0] d);
      bus_addr = a;
      bus_data = d;
      io_write_n = 1'b0;
      repeat (2) @(negedge clk);
      io_write_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Longest path is one refresh wait plus the scenarios
   initial begin
      #(25ns * 6000);
      n_errors++;
      wrap_up();
   end
   initial begin
      {sys_rst, size_jumper, memory_read_n, memory_write_n, io_read_n, io_write_n} = 6'h3f;
      {base_jumper, dma_upper_addr_strobe, floppy_req, ready_in, dma_addr_enable_n} = 5'h3;
      {bus_addr, bus_data, dma_addr_lo, dma_cmd_n, ack_hi, bus_req} = {20'h0, 16'h005a, 7'h7f, 2'h0};
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 800 && refresh_cycle !== 1'b1; i++) @(negedge clk);
      check("refresh", 20'h1, 20'(refresh_cycle));
      mem_cycle({12'h000, rf_row}, 1'b0, 4'h0);
      for (int i = 0; i < 100 && refresh_cycle !== 1'b0; i++) @(negedge clk);
      floppy_req = 1'b1;
      repeat (2) @(negedge clk);
      check("req", 20'h1, 20'(dma_req[2]));
      io_wr(20'h00008, 8'h00);
      for (int k = 0; k < 3; k++) begin
         io_wr(20'h81 + 20'(k), 8'hf5 + 8'(k));
         dma_addr_enable_n = 1'b0;
         dma_cmd_n = 4'h6;
         ack_hi = ack_tab[k];
         dma_upper_addr_strobe = 1'b1;
         bus_data = 8'hc3;
         @(negedge clk);
         dma_upper_addr_strobe = 1'b0;
         repeat (3) @(negedge clk);
         check("dma", {4'(k + 5), 16'hc35a}, dma_addr_out);
         check("oe", 20'h1, 20'(dma_addr_oe));
         check("cmd", 20'h6, 20'(bus_cmd_n));
         check("buf", 20'h0, 20'(data_buf_en_n));
         check("ack", 20'({ack_hi[1], ack_hi[2], ack_hi[0]}),
               20'({floppy_ack_n, bus_ack_n}));
         io_read_n = 1'b0;
         repeat (2) @(negedge clk);
         check("rdy", 20'h0, 20'(dma_ready));
         io_read_n = 1'b1;
         repeat (14) @(negedge clk);
         check("rdy", 20'h1, 20'(dma_ready));
         {dma_addr_enable_n, dma_cmd_n, ack_hi} = 8'hff;
         @(negedge clk);
      end
      mem_cycle(20'h30000, 1'b0, 4'h7);
      mem_cycle(20'h2abcd, 1'b1, 4'hb);
      size_jumper = 1'b0;
      mem_cycle(20'h30000, 1'b0, 4'hf);
      mem_cycle(20'h1ab12, 1'b0, 4'hd);
      base_jumper = 1'b1;
      io_wr(20'h83, 8'h0a);
      check("page", 20'h7, 20'(dma_addr_out[19:16]));
      mem_cycle(20'h40000, 1'b0, 4'he);
      mem_cycle(20'h00000, 1'b0, 4'hf);
      wrap_up();
   end
endmodule
bind memory_board_dram_dma_glue memboard_checker #(.WAIT_OSC_EDGES(WAIT_OSC_EDGES)) chk (.*);
